// ===== src/uuls_top.sv
`timescale 1ns/1ps
`include "uuls_regs.svh"

module uuls_top (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [17:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  input wire logic limit_pos_pin,
  input wire logic limit_neg_pin,
  input wire logic sw_limit_pos,
  input wire logic sw_limit_neg,
  input wire logic signed [31:0] actual_position,
  input wire logic standstill,
  output logic move_block_pos,
  output logic move_block_neg,
  output logic driver_enable,
  output logic ramp_active,
  output logic ramp_quick,
  output logic [2:0] power_state,
  output logic warning,
  output logic [7:0] pos_unit_code,
  output logic signed [7:0] pos_unit_exp,
  output logic feed_apply,
  output logic [31:0] feed,
  output logic [31:0] shaft_rev,
  output logic [7:0] spd_time_code,
  output logic [7:0] spd_pos_code,
  output logic signed [7:0] spd_unit_exp,
  output logic [31:0] spd_num,
  output logic [31:0] spd_den,
  output logic [31:0] acc_num,
  output logic [31:0] acc_den,
  output logic [31:0] jrk_num,
  output logic [31:0] jrk_den
);

  // --------------------------------------------------------------------------
  // Register decode.
  // --------------------------------------------------------------------------
  wire logic [15:0] idx = reg_addr[17:2];
  wire logic aligned = (reg_addr[1:0] == 2'h0);
  wire logic wr = reg_write & aligned;
  wire logic rd = reg_read & aligned;
  wire logic wr_pos_unit = wr & (idx == `UULS_IDX_POS_UNIT);
  wire logic wr_spd_unit = wr & (idx == `UULS_IDX_SPD_UNIT);
  wire logic wr_spd_num = wr & (idx == `UULS_IDX_SPD_NUM);
  wire logic wr_spd_den = wr & (idx == `UULS_IDX_SPD_DEN);
  wire logic wr_acc_num = wr & (idx == `UULS_IDX_ACC_NUM);
  wire logic wr_acc_den = wr & (idx == `UULS_IDX_ACC_DEN);
  wire logic wr_jrk_num = wr & (idx == `UULS_IDX_JRK_NUM);
  wire logic wr_jrk_den = wr & (idx == `UULS_IDX_JRK_DEN);
  wire logic wr_feed = wr & (idx == `UULS_IDX_FEED);
  wire logic wr_shaft = wr & (idx == `UULS_IDX_SHAFT_REV);
  wire logic wr_vmsf_num = wr & (idx == `UULS_IDX_VMSF_NUM);
  wire logic wr_vmsf_den = wr & (idx == `UULS_IDX_VMSF_DEN);
  wire logic wr_react = wr & (idx == `UULS_IDX_REACTION);
  wire logic wr_ctrl = wr & (idx == `UULS_IDX_CONTROL);

  // Staged values as written by software.
  logic [15:0] pos_unit_q;
  logic [23:0] spd_unit_q;
  logic [31:0] spd_num_q, spd_den_q, acc_num_q, acc_den_q, jrk_num_q, jrk_den_q;
  logic [31:0] feed_q, shaft_q, vmsf_num_q, vmsf_den_q;
  logic [7:0] react_q;
  logic [7:0] ctrl_q;

  // A reaction write outside the valid set leaves the old code in place.
  wire logic react_ok = (reg_wdata == 32'hFFFFFFFE) || (reg_wdata == 32'hFFFFFFFF) ||
                        (reg_wdata == 32'h00000000) || (reg_wdata == 32'h00000001) ||
                        (reg_wdata == 32'h00000002) || (reg_wdata == 32'h00000005) ||
                        (reg_wdata == 32'h00000006);

  always_ff @(posedge mclk) begin
    if (reset) begin
      pos_unit_q <= 16'(`UULS_RST_POS_UNIT >> 16);
      spd_unit_q <= 24'(`UULS_RST_SPD_UNIT >> 8);
      spd_num_q <= `UULS_RST_FACTOR;
      spd_den_q <= `UULS_RST_FACTOR;
      acc_num_q <= `UULS_RST_FACTOR;
      acc_den_q <= `UULS_RST_FACTOR;
      jrk_num_q <= `UULS_RST_FACTOR;
      jrk_den_q <= `UULS_RST_FACTOR;
      feed_q <= `UULS_RST_FACTOR;
      shaft_q <= `UULS_RST_FACTOR;
      vmsf_num_q <= `UULS_RST_FACTOR;
      vmsf_den_q <= `UULS_RST_FACTOR;
      react_q <= `UULS_RST_REACTION;
      ctrl_q <= `UULS_RST_CONTROL;
    end else begin
      if (wr_pos_unit) begin
        pos_unit_q <= reg_wdata[`UULS_UNIT_EXP_MSB:`UULS_UNIT_POS_LSB];
      end
      if (wr_spd_unit) begin
        spd_unit_q <= reg_wdata[`UULS_UNIT_EXP_MSB:`UULS_UNIT_TIME_LSB];
      end
      if (wr_spd_num) spd_num_q <= reg_wdata;
      if (wr_spd_den) spd_den_q <= reg_wdata;
      if (wr_acc_num) acc_num_q <= reg_wdata;
      if (wr_acc_den) acc_den_q <= reg_wdata;
      if (wr_jrk_num) jrk_num_q <= reg_wdata;
      if (wr_jrk_den) jrk_den_q <= reg_wdata;
      if (wr_feed) feed_q <= reg_wdata;
      if (wr_shaft) shaft_q <= reg_wdata;
      if (wr_vmsf_num) vmsf_num_q <= reg_wdata;
      if (wr_vmsf_den) vmsf_den_q <= reg_wdata;
      if (wr_react && react_ok) begin
        react_q <= reg_wdata[7:0];
      end
      if (wr_ctrl) ctrl_q <= reg_wdata[7:0];
    end
  end

  // --------------------------------------------------------------------------
  // Limit sources.
  // --------------------------------------------------------------------------
  logic [1:0] pin_meta_q, pin_sync_q;
  logic [1:0] src_prev_q;

  always_ff @(posedge mclk) begin
    if (reset) begin
      pin_meta_q <= 2'h0;
      pin_sync_q <= 2'h0;
    end else begin
      pin_meta_q <= {limit_neg_pin, limit_pos_pin};
      pin_sync_q <= pin_meta_q;
    end
  end

  wire logic src_pos = (pin_sync_q[0] & ctrl_q[`UULS_CTRL_HWEN_POS_BIT]) | sw_limit_pos;
  wire logic src_neg = (pin_sync_q[1] & ctrl_q[`UULS_CTRL_HWEN_NEG_BIT]) | sw_limit_neg;
  wire logic trig_pos = src_pos & ~src_prev_q[0];
  wire logic trig_neg = src_neg & ~src_prev_q[1];
  wire logic trig = trig_pos | trig_neg;

  // --------------------------------------------------------------------------
  // Latched limit position and warning.
  // --------------------------------------------------------------------------
  uuls_pkg::uuls_pos_t lim_pos_q;
  logic lim_valid_q;
  logic lim_side_pos_q;
  logic warn_q;

  wire logic code_discard = (react_q == `UULS_REACT_DISCARD);
  wire logic code_note = (react_q == `UULS_REACT_NOTE);
  wire logic code_blocks = ~code_discard & ~code_note;
  wire logic at_latch = lim_valid_q & (actual_position == lim_pos_q);
  wire logic warn_clear = code_discard ? (~src_pos & ~src_neg) : at_latch;

  always_ff @(posedge mclk) begin
    if (reset) begin
      src_prev_q <= 2'h0;
      lim_pos_q <= 32'h00000000;
      lim_valid_q <= 1'b0;
      lim_side_pos_q <= 1'b0;
      warn_q <= 1'b0;
    end else begin
      src_prev_q <= {src_neg, src_pos};
      if (trig) begin
        lim_pos_q <= actual_position;
        lim_side_pos_q <= trig_pos;
        lim_valid_q <= ~code_discard;
      end else if (code_discard) begin
        lim_valid_q <= 1'b0;
      end
      // A new trigger wins over a clear in the same cycle.
      if (trig) begin
        warn_q <= 1'b1;
      end else if (warn_clear) begin
        warn_q <= 1'b0;
      end
    end
  end

  // Only travel further past the latch is blocked.
  wire logic past_pos = lim_side_pos_q & (actual_position >= lim_pos_q);
  wire logic past_neg = ~lim_side_pos_q & (actual_position <= lim_pos_q);
  wire logic block_pos_d = lim_valid_q & code_blocks & past_pos;
  wire logic block_neg_d = lim_valid_q & code_blocks & past_neg;

  // --------------------------------------------------------------------------
  // Power state machine.
  // --------------------------------------------------------------------------
  uuls_pkg::uuls_state_t state_q, state_d;
  logic qstop_prev_q;
  logic ramp_quick_q, ramp_quick_d;

  wire logic qstop_bit = ctrl_q[`UULS_CTRL_QSTOP_BIT];
  wire logic qstop_rise = qstop_bit & ~qstop_prev_q;
  wire logic enable_bit = ctrl_q[`UULS_CTRL_ENABLE_BIT];

  always_comb begin
    state_d = state_q;
    ramp_quick_d = ramp_quick_q;
    case (state_q)
      uuls_pkg::uuls_st_sod: begin
        if (enable_bit && qstop_bit) begin
          state_d = uuls_pkg::uuls_st_open;
        end
      end
      uuls_pkg::uuls_st_open: begin
        if (trig) begin
          case (react_q)
            `UULS_REACT_OFF: state_d = uuls_pkg::uuls_st_sod;
            `UULS_REACT_SLOW_OFF: begin
              state_d = uuls_pkg::uuls_st_brake_off;
              ramp_quick_d = 1'b0;
            end
            `UULS_REACT_QUICK_OFF: begin
              state_d = uuls_pkg::uuls_st_brake_off;
              ramp_quick_d = 1'b1;
            end
            `UULS_REACT_SLOW_QS: begin
              state_d = uuls_pkg::uuls_st_brake_qs;
              ramp_quick_d = 1'b0;
            end
            `UULS_REACT_QUICK_QS: begin
              state_d = uuls_pkg::uuls_st_brake_qs;
              ramp_quick_d = 1'b1;
            end
            default: state_d = uuls_pkg::uuls_st_open;
          endcase
        end else if (!enable_bit) begin
          state_d = uuls_pkg::uuls_st_sod;
        end
      end
      uuls_pkg::uuls_st_brake_off: begin
        if (standstill) begin
          state_d = uuls_pkg::uuls_st_sod;
        end
      end
      uuls_pkg::uuls_st_brake_qs: begin
        if (standstill) begin
          state_d = uuls_pkg::uuls_st_qsa;
        end
      end
      uuls_pkg::uuls_st_qsa: begin
        if (!enable_bit) begin
          state_d = uuls_pkg::uuls_st_sod;
        end else if (qstop_rise) begin
          state_d = uuls_pkg::uuls_st_open;
        end
      end
      default: state_d = uuls_pkg::uuls_st_sod;
    endcase
  end

  wire logic braking = (state_d == uuls_pkg::uuls_st_brake_off) ||
                       (state_d == uuls_pkg::uuls_st_brake_qs);
  wire logic energised = (state_d != uuls_pkg::uuls_st_sod);

  // --------------------------------------------------------------------------
  // Applied units; copied only while not in operation enabled.
  // --------------------------------------------------------------------------
  wire logic apply_units = (state_q != uuls_pkg::uuls_st_open);
  wire logic vel_mode = ctrl_q[`UULS_CTRL_VELMODE_BIT];
  wire logic [7:0] pcode = pos_unit_q[7:0];
  wire logic len_unit = (pcode == `UULS_UNIT_DIMLESS) || (pcode == `UULS_UNIT_METER) ||
                        (pcode == `UULS_UNIT_INCH) || (pcode == `UULS_UNIT_FOOT);
  wire logic [23:0] rpm_unit = 24'(`UULS_RST_SPD_UNIT >> 8);
  wire logic [23:0] spd_unit_eff = vel_mode ? rpm_unit : spd_unit_q;
  wire logic [31:0] spd_num_eff = vel_mode ? vmsf_num_q : spd_num_q;
  wire logic [31:0] spd_den_eff = vel_mode ? vmsf_den_q : spd_den_q;

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_q <= uuls_pkg::uuls_st_sod;
      qstop_prev_q <= 1'b0;
      ramp_quick_q <= 1'b0;
      move_block_pos <= 1'b0;
      move_block_neg <= 1'b0;
      driver_enable <= 1'b0;
      ramp_active <= 1'b0;
      ramp_quick <= 1'b0;
      power_state <= 3'h0;
      warning <= 1'b0;
    end else begin
      state_q <= state_d;
      qstop_prev_q <= qstop_bit;
      ramp_quick_q <= ramp_quick_d;
      move_block_pos <= block_pos_d;
      move_block_neg <= block_neg_d;
      driver_enable <= energised;
      ramp_active <= braking;
      ramp_quick <= ramp_quick_d & braking;
      power_state <= state_d;
      warning <= warn_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      pos_unit_code <= 8'h41;
      pos_unit_exp <= 8'hFF;
      feed_apply <= 1'b0;
      feed <= `UULS_RST_FACTOR;
      shaft_rev <= `UULS_RST_FACTOR;
      spd_time_code <= 8'h47;
      spd_pos_code <= 8'hB4;
      spd_unit_exp <= 8'h00;
      spd_num <= `UULS_RST_FACTOR;
      spd_den <= `UULS_RST_FACTOR;
      acc_num <= `UULS_RST_FACTOR;
      acc_den <= `UULS_RST_FACTOR;
      jrk_num <= `UULS_RST_FACTOR;
      jrk_den <= `UULS_RST_FACTOR;
    end else if (apply_units) begin
      pos_unit_code <= pcode;
      pos_unit_exp <= $signed(pos_unit_q[15:8]);
      feed_apply <= len_unit;
      feed <= feed_q;
      shaft_rev <= shaft_q;
      spd_time_code <= spd_unit_eff[7:0];
      spd_pos_code <= spd_unit_eff[15:8];
      spd_unit_exp <= $signed(spd_unit_eff[23:16]);
      spd_num <= spd_num_eff;
      spd_den <= spd_den_eff;
      acc_num <= acc_num_q;
      acc_den <= acc_den_q;
      jrk_num <= jrk_num_q;
      jrk_den <= jrk_den_q;
    end
  end

  // --------------------------------------------------------------------------
  // Read path; data stand only in the cycle after the strobe.
  // --------------------------------------------------------------------------
  logic [31:0] rsel;

  always_comb begin
    rsel = 32'h00000000;
    case (idx)
      `UULS_IDX_POS_UNIT: rsel = {pos_unit_q, 16'h0000};
      `UULS_IDX_SPD_UNIT: rsel = {spd_unit_q, 8'h00};
      `UULS_IDX_SPD_NUM: rsel = spd_num_q;
      `UULS_IDX_SPD_DEN: rsel = spd_den_q;
      `UULS_IDX_ACC_NUM: rsel = acc_num_q;
      `UULS_IDX_ACC_DEN: rsel = acc_den_q;
      `UULS_IDX_JRK_NUM: rsel = jrk_num_q;
      `UULS_IDX_JRK_DEN: rsel = jrk_den_q;
      `UULS_IDX_FEED: rsel = feed_q;
      `UULS_IDX_SHAFT_REV: rsel = shaft_q;
      `UULS_IDX_VMSF_NUM: rsel = vmsf_num_q;
      `UULS_IDX_VMSF_DEN: rsel = vmsf_den_q;
      `UULS_IDX_REACTION: rsel = {{24{react_q[7]}}, react_q};
      `UULS_IDX_CONTROL: rsel = {24'h000000, ctrl_q};
      `UULS_IDX_STATUS: rsel = {22'h0, lim_side_pos_q, lim_valid_q, warn_q,
                                4'h0, state_q};
      `UULS_IDX_LATCH_POS: rsel = lim_pos_q;
      default: rsel = 32'h00000000;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      reg_rdata <= 32'h00000000;
    end else begin
      reg_rdata <= rd ? rsel : 32'h00000000;
    end
  end

endmodule : uuls_top

// ===== src/uuls_regs.svh
`ifndef UULS_REGS_SVH
`define UULS_REGS_SVH

// ----------------------------------------------------------------------------
// Register indices; the byte address is four times the index.
// ----------------------------------------------------------------------------
`define UULS_IDX_POS_UNIT 16'h60A8
`define UULS_IDX_SPD_UNIT 16'h60A9
`define UULS_IDX_SPD_NUM 16'h7000
`define UULS_IDX_SPD_DEN 16'h7001
`define UULS_IDX_ACC_NUM 16'h7002
`define UULS_IDX_ACC_DEN 16'h7003
`define UULS_IDX_JRK_NUM 16'h7004
`define UULS_IDX_JRK_DEN 16'h7005
`define UULS_IDX_FEED 16'h7006
`define UULS_IDX_SHAFT_REV 16'h7007
`define UULS_IDX_VMSF_NUM 16'h7008
`define UULS_IDX_VMSF_DEN 16'h7009
`define UULS_IDX_REACTION 16'h700A
`define UULS_IDX_CONTROL 16'h700B
`define UULS_IDX_STATUS 16'h700C
`define UULS_IDX_LATCH_POS 16'h700D

// ----------------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------------
`define UULS_UNIT_EXP_MSB 31
`define UULS_UNIT_EXP_LSB 24
`define UULS_UNIT_POS_MSB 23
`define UULS_UNIT_POS_LSB 16
`define UULS_UNIT_TIME_MSB 15
`define UULS_UNIT_TIME_LSB 8
`define UULS_CTRL_ENABLE_BIT 0
`define UULS_CTRL_QSTOP_BIT 2
`define UULS_CTRL_VELMODE_BIT 3
`define UULS_CTRL_HWEN_POS_BIT 4
`define UULS_CTRL_HWEN_NEG_BIT 5
`define UULS_STAT_WARN_BIT 7
`define UULS_STAT_VALID_BIT 8
`define UULS_STAT_SIDE_BIT 9

// ----------------------------------------------------------------------------
// Reset values and codes.
// ----------------------------------------------------------------------------
`define UULS_RST_POS_UNIT 32'hFF410000
`define UULS_RST_SPD_UNIT 32'h00B44700
`define UULS_RST_FACTOR 32'h00000001
`define UULS_RST_CONTROL 8'h00
`define UULS_RST_REACTION 8'hFF
`define UULS_REACT_DISCARD 8'hFE
`define UULS_REACT_NOTE 8'hFF
`define UULS_REACT_OFF 8'h00
`define UULS_REACT_SLOW_OFF 8'h01
`define UULS_REACT_QUICK_OFF 8'h02
`define UULS_REACT_SLOW_QS 8'h05
`define UULS_REACT_QUICK_QS 8'h06
`define UULS_UNIT_DIMLESS 8'h00
`define UULS_UNIT_METER 8'h01
`define UULS_UNIT_INCH 8'hC1
`define UULS_UNIT_FOOT 8'hC2

`endif

// ===== src/uuls_pkg.sv
package uuls_pkg;

  typedef enum logic [2:0] {
    uuls_st_sod = 3'h0,
    uuls_st_open = 3'h1,
    uuls_st_brake_off = 3'h2,
    uuls_st_brake_qs = 3'h3,
    uuls_st_qsa = 3'h4
  } uuls_state_t;

  typedef logic signed [31:0] uuls_pos_t;

endpackage : uuls_pkg

// ===== verif/uuls_switch_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Cam-operated limit switches on the axis; contacts are pulled low when open.
// ----------------------------------------------------------------------------
module uuls_switch_model #(
  parameter int LIMIT_AT = 1000
) (
  input wire logic mclk,
  input wire logic signed [31:0] actual_position,
  output logic limit_pos_pin,
  output logic limit_neg_pin
);
  initial begin
    limit_pos_pin = 1'b0;
    limit_neg_pin = 1'b0;
  end

  // Contacts move a few ns after the edge, so the pins stay unrelated to the clock.
  always @(posedge mclk) begin
    #3;
    limit_pos_pin <= actual_position >= LIMIT_AT;
    limit_neg_pin <= actual_position <= -LIMIT_AT;
  end
endmodule : uuls_switch_model

// ===== verif/uuls_top_chk.sv
`timescale 1ns/1ps

module uuls_top_chk (
  input wire logic mclk,
  input wire logic reset,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic limit_pos_pin,
  input wire logic sw_limit_pos,
  input wire logic standstill,
  input wire logic move_block_pos,
  input wire logic move_block_neg,
  input wire logic driver_enable,
  input wire logic ramp_active,
  input wire logic [2:0] power_state,
  input wire logic warning,
  input wire logic [7:0] pos_unit_code,
  input wire logic feed_apply,
  input wire logic [31:0] spd_num
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  sequence s_trig;
    !sw_limit_pos ##1 sw_limit_pos && !limit_pos_pin ##1 sw_limit_pos;
  endsequence
  sequence s_qs_exit;
    power_state == 3'h4 ##1 power_state == 3'h1;
  endsequence

  chk_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
    else $error("read data present without a read");
  chk_warn_set: assert property (s_trig |=> warning)
    else $error("warning not raised after limit trigger");
  chk_drv_state: assert property (driver_enable == (power_state != 3'h0))
    else $error("driver enable disagrees with power state");
  chk_ramp_state: assert property (ramp_active == power_state inside {3'h2, 3'h3})
    else $error("ramp flag disagrees with power state");
  chk_ramp_qsa: assert property (power_state == 3'h3 && standstill |=> power_state == 3'h4)
    else $error("braking did not end in quick stop active");
  chk_ramp_sod: assert property (power_state == 3'h2 && standstill |=> power_state == 3'h0)
    else $error("braking did not end in switch on disabled");
  chk_qs_exit: assert property (s_qs_exit |-> $past(reg_write, 2) || $past(reg_write, 3))
    else $error("quick stop left without a control write");
  chk_block_excl: assert property (!(move_block_pos && move_block_neg))
    else $error("both motion directions blocked");
  chk_feed_unit: assert property (feed_apply == pos_unit_code inside {8'h00, 8'h01, 8'hC1, 8'hC2})
    else $error("feed constant use disagrees with unit");
  chk_units_hold: assert property (power_state == 3'h1 && $past(power_state) == 3'h1
    |-> $stable(pos_unit_code) && $stable(spd_num))
    else $error("unit outputs changed in operation enabled");
endmodule : uuls_top_chk

bind uuls_top uuls_top_chk i_uuls_top_chk (.mclk, .reset, .reg_write, .reg_read, .reg_rdata,
  .limit_pos_pin, .sw_limit_pos, .standstill, .move_block_pos, .move_block_neg, .driver_enable,
  .ramp_active, .power_state, .warning, .pos_unit_code, .feed_apply, .spd_num);

// ===== verif/tb.sv
`timescale 1ns/1ps
`include "uuls_regs.svh"

module tb;
  localparam logic [15:0] r_pos = `UULS_IDX_POS_UNIT;
  localparam logic [15:0] r_spd = `UULS_IDX_SPD_UNIT;
  localparam logic [15:0] r_rct = `UULS_IDX_REACTION;
  localparam logic [15:0] r_ctl = `UULS_IDX_CONTROL;
  localparam logic [15:0] r_sta = `UULS_IDX_STATUS;
  localparam logic [15:0] r_lat = `UULS_IDX_LATCH_POS;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [17:0] reg_addr = 18'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_write = 1'b0, reg_read = 1'b0, sw_limit_pos = 1'b0, sw_limit_neg = 1'b0;
  logic standstill = 1'b0;
  logic signed [31:0] actual_position = 32'sh0;
  logic limit_pos_pin, limit_neg_pin, move_block_pos, move_block_neg, driver_enable;
  logic ramp_active, ramp_quick, warning, feed_apply;
  logic [2:0] power_state;
  logic [7:0] pos_unit_code, spd_time_code, spd_pos_code;
  logic signed [7:0] pos_unit_exp, spd_unit_exp;
  logic [31:0] reg_rdata, feed, shaft_rev, spd_num, spd_den, acc_num, acc_den, jrk_num, jrk_den;
  logic [31:0] v;
  int n_mismatch = 0, num_checks = 0;

  always #10 mclk = ~mclk;

  uuls_top i_uuls_top (.mclk, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .limit_pos_pin, .limit_neg_pin, .sw_limit_pos, .sw_limit_neg, .actual_position, .standstill,
    .move_block_pos, .move_block_neg, .driver_enable, .ramp_active, .ramp_quick, .power_state,
    .warning, .pos_unit_code, .pos_unit_exp, .feed_apply, .feed, .shaft_rev, .spd_time_code,
    .spd_pos_code, .spd_unit_exp, .spd_num, .spd_den, .acc_num, .acc_den, .jrk_num, .jrk_den);
  uuls_switch_model i_uuls_switch_model (.mclk, .actual_position, .limit_pos_pin, .limit_neg_pin);

  // --------------------------------------------------------------------------
  // Bus cycles and comparison.
  // --------------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask : cyc

  task automatic wr(input logic [15:0] i, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= {i, 2'b00};
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge mclk);
    reg_write <= 1'b0;
  endtask : wr

  task automatic rc(input logic [15:0] i, input logic [31:0] exp);
    @(posedge mclk);
    reg_addr <= {i, 2'b00};
    reg_read <= 1'b1;
    @(posedge mclk);
    reg_read <= 1'b0;
    @(negedge mclk);
    v = reg_rdata;
    chk(v, exp);
  endtask : rc

  task automatic go_op;
    wr(r_ctl, 32'h5);
    cyc(2);
    chk(power_state, 32'h1);
  endtask : go_op

  // --------------------------------------------------------------------------
  // Scenarios.
  // --------------------------------------------------------------------------
  task automatic t_units;
    rc(r_pos, 32'hFF410000);
    rc(r_spd, 32'h00B44700);
    rc(r_rct, 32'hFFFFFFFF);
    rc(16'h1234, 32'h0);
    chk(pos_unit_exp, 32'hFFFFFFFF);
    chk(feed_apply, 32'h0);
    wr(r_pos, 32'hFD01ABCD);
    wr(16'h7006, 32'h7);
    wr(16'h7007, 32'h3);
    wr(r_spd, 32'hFD010300);
    for (int k = 0; k < 6; k++) wr(16'h7000 + k[15:0], k + 2);
    cyc(2);
    rc(r_pos, 32'hFD010000);
    chk(pos_unit_code, 32'h1);
    chk(pos_unit_exp, 32'hFFFFFFFD);
    chk({feed_apply, feed[3:0], shaft_rev[3:0]}, 32'h173);
    chk({spd_unit_exp, spd_pos_code, spd_time_code}, 32'hFD0103);
    chk({spd_num[3:0], spd_den[3:0]}, 32'h23);
    chk({acc_num[3:0], acc_den[3:0]}, 32'h45);
    chk({jrk_num[3:0], jrk_den[3:0]}, 32'h67);
    wr(16'h7008, 32'h9);
    wr(16'h7009, 32'h4);
    wr(r_ctl, 32'h8);
    cyc(2);
    chk({spd_unit_exp, spd_pos_code, spd_time_code}, 32'hB447);
    chk({spd_num[3:0], spd_den[3:0]}, 32'h94);
    go_op;
    wr(r_pos, 32'hFF410000);
    cyc(2);
    chk(pos_unit_code, 32'h1);
    wr(r_ctl, 32'h0);
    cyc(3);
    chk(pos_unit_code, 32'h41);
    $display("t_units done");
  endtask : t_units

  task automatic t_limit;
    wr(r_rct, 32'h6);
    go_op;
    @(posedge mclk) actual_position <= 32'sd100;
    @(posedge mclk) sw_limit_pos <= 1'b1;
    @(posedge mclk) actual_position <= 32'sd150;
    @(negedge mclk);
    chk({ramp_active, ramp_quick, power_state}, 32'h1B);
    cyc(1);
    chk(warning, 32'h1);
    rc(r_lat, 32'd100);
    chk({move_block_pos, move_block_neg}, 32'h2);
    @(posedge mclk) standstill <= 1'b1;
    cyc(2);
    chk({driver_enable, power_state}, 32'hC);
    wr(r_ctl, 32'h1);
    cyc(2);
    chk(power_state, 32'h4);
    wr(r_ctl, 32'h5);
    cyc(2);
    chk(power_state, 32'h1);
    wr(r_rct, 32'hFFFFFFFE);
    @(posedge mclk) sw_limit_pos <= 1'b0;
    cyc(3);
    chk({warning, move_block_pos}, 32'h0);
    rc(r_sta, 32'h201);
    wr(r_rct, 32'h6);
    wr(r_rct, 32'hFFFFFFFF);
    @(posedge mclk) actual_position <= 32'sd200;
    @(posedge mclk) sw_limit_pos <= 1'b1;
    @(posedge mclk) actual_position <= 32'sd300;
    cyc(3);
    chk({power_state, move_block_pos}, 32'h2);
    rc(r_sta, 32'h381);
    @(posedge mclk) sw_limit_pos <= 1'b0;
    cyc(3);
    chk(warning, 32'h1);
    @(posedge mclk) actual_position <= 32'sd200;
    cyc(3);
    chk(warning, 32'h0);
    wr(r_rct, 32'h3);
    wr(r_rct, 32'h106);
    rc(r_rct, 32'hFFFFFFFF);
    $display("t_limit done");
  endtask : t_limit

  task automatic t_codes;
    logic [31:0] cd [4] = '{32'h0, 32'h1, 32'h2, 32'h5};
    logic [31:0] mx [4] = '{32'h0, 32'h32, 32'h3A, 32'h33};
    logic [31:0] fx [4] = '{32'h0, 32'h0, 32'h0, 32'h24};
    for (int k = 0; k < 4; k++) begin
      wr(r_rct, 32'hFFFFFFFE);
      @(posedge mclk);
      sw_limit_pos <= 1'b0;
      standstill <= 1'b0;
      wr(r_ctl, 32'h0);
      wr(r_rct, cd[k]);
      go_op;
      @(posedge mclk) sw_limit_pos <= 1'b1;
      cyc(1);
      chk({driver_enable, ramp_active, ramp_quick, power_state}, mx[k]);
      @(posedge mclk) standstill <= 1'b1;
      cyc(1);
      if (k > 0) chk({driver_enable, ramp_active, ramp_quick, power_state}, fx[k]);
    end
    $display("t_codes done");
  endtask : t_codes

  task automatic t_pin;
    wr(r_rct, 32'hFFFFFFFE);
    @(posedge mclk);
    sw_limit_pos <= 1'b0;
    standstill <= 1'b0;
    actual_position <= 32'sd1000;
    wr(r_ctl, 32'h0);
    wr(r_rct, 32'hFFFFFFFF);
    cyc(6);
    chk(warning, 32'h0);
    wr(r_ctl, 32'h10);
    @(posedge mclk) actual_position <= 32'sd1100;
    cyc(6);
    chk(warning, 32'h1);
    rc(r_lat, 32'd1000);
    wr(r_rct, 32'hFFFFFFFE);
    rc(r_sta, 32'h280);
    wr(r_rct, 32'h6);
    @(posedge mclk) sw_limit_neg <= 1'b1;
    cyc(2);
    chk({move_block_pos, move_block_neg}, 32'h1);
    $display("t_pin done");
  endtask : t_pin

  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    t_units;
    t_limit;
    t_codes;
    t_pin;
    report_and_stop;
  end

  initial begin
    repeat (5000) @(posedge mclk);
    n_mismatch++;
    report_and_stop;
  end
endmodule : tb
